// >>> logic/pdo_mapper.sv
// Cyclic process-data mapper top module
`timescale 1ns/1ns
`include "pdo_mapper_cfg.svh"
module pdo_mapper
(
   // Clock and reset
   input  wire logic                           clk_i,
   input  wire logic                           resetn_i,
   // Configuration
   input  wire logic                           stepper_i,
   input  wire logic                           eight_slots_i,
   input  wire logic                           sync_mode_i,
   input  wire logic                           sync0_i,
   // Mapping storage and service port
   input  wire logic                           map_wr_i,
   input  wire logic [4:0]                     map_sub_i,
   input  wire logic [31:0]                    map_data_i,
   input  wire logic                           save_i,
   // Receive object from master
   input  wire pdo_mapper_pkg::slot_word_type  rx_word_i,
   input  wire logic                           rx_frame_end_i,
   // Transmit request and motor read data
   input  wire logic                           tx_start_i,
   input  wire logic [31:0]                    motor_rdata_i,
   // Software register port
   input  wire logic [3:0]                     addr_i,
   input  wire logic [31:0]                    wdata_i,
   input  wire logic                           wr_i,
   input  wire logic                           rd_i,
   // Outputs
   output logic [31:0]                         rdata_o,
   output pdo_mapper_pkg::reg_access_type      motor_wr_o,
   output logic [15:0]                         motor_raddr_o,
   output pdo_mapper_pkg::slot_word_type       tx_word_o,
   output logic                                general_output_one_o
);
   import pdo_mapper_pkg::*;

   // ==========================================================
   // Reset synchroniser
   logic rst_meta_reg;
   logic rst_sync_reg;
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   wire logic rst_n = rst_sync_reg;

   // ==========================================================
   // Mapping: staged copy, saved copy, active copy from power-up
   logic [31:0] stage_tx_reg [`SLOTS];
   logic [31:0] stage_rx_reg [`SLOTS];
   logic [31:0] saved_tx_reg [`SLOTS];
   logic [31:0] saved_rx_reg [`SLOTS];
   logic [31:0] act_tx_reg [`SLOTS];
   logic [31:0] act_rx_reg [`SLOTS];
   logic        user_map_reg;
   logic        saved_user_reg;
   logic        loaded_reg;
   // Flag of the nonvolatile model; the load reads it directly because its registered
   // copy only becomes valid in the same cycle as the load
   logic        saved_valid_reg = 1'b0;

   function automatic logic [31:0] dflt(input logic tx, input logic stp, input int s);
      logic [15:0] r;
      r = 16'h0000;
      case (s)
         0: r = `R_MODE;
         1: r = tx ? `R_POS_ACT : `R_POS_TGT;
         2: r = tx ? `R_VEL_ACT : `R_VEL_LIM;
         3: r = tx ? (stp ? `R_STATUS : `R_TRQ_ACT)
                   : (stp ? `R_ACC_REQ : `R_TRQ_LIM); // (R11) (R12) (R13) (R14)
         4: r = tx ? (stp ? `R_WARN : `R_STATUS) : 16'h0000;
         default: r = 16'h0000;
      endcase
      return {16'h0000, r};
   endfunction

   // Mapping only changes at load after reset; a save without reset has no effect
   genvar g;
   generate
      for (g = 0; g < `SLOTS; g++)
      begin : map_g
         always_ff @(posedge clk_i or negedge rst_n)
         begin
            if (!rst_n)
            begin
               stage_tx_reg[g] <= 32'h0;
               stage_rx_reg[g] <= 32'h0;
               act_tx_reg[g]   <= 32'h0;
               act_rx_reg[g]   <= 32'h0;
            end
            else
            begin
               if (map_wr_i && map_sub_i == 5'(`MAP_BASE_SUB - 16 + g))
                  stage_rx_reg[g] <= map_data_i; // (R7)
               if (map_wr_i && map_sub_i == 5'(`MAP_BASE_SUB - 16 + `SLOTS + g))
                  stage_tx_reg[g] <= map_data_i; // (R7)
               if (!loaded_reg)
               begin
                  act_tx_reg[g] <= saved_valid_reg ? saved_tx_reg[g] : dflt(1'b1, stepper_i, g);
                  act_rx_reg[g] <= saved_valid_reg ? saved_rx_reg[g] : dflt(1'b0, stepper_i, g);
               end
            end
         end
         // Saved copy models nonvolatile storage, so it is not cleared by reset
         always_ff @(posedge clk_i)
         begin
            if (save_i && user_map_reg)
            begin
               saved_tx_reg[g] <= stage_tx_reg[g]; // (R7)
               saved_rx_reg[g] <= stage_rx_reg[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i)
   begin
      if (save_i && user_map_reg)
         saved_valid_reg <= 1'b1;
   end
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         user_map_reg   <= 1'b0;
         saved_user_reg <= 1'b0;
         loaded_reg     <= 1'b0;
      end
      else
      begin
         if (map_wr_i)
            user_map_reg <= 1'b1;
         if (!loaded_reg)
            saved_user_reg <= saved_valid_reg;
         loaded_reg <= 1'b1;
      end
   end

   wire logic [`SLOT_W:0] slot_lim = eight_slots_i ? 4'(`SLOTS) : 4'(`SLOTS_SHORT); // (R5)

   // ==========================================================
   // Receive path: buffer words, then apply at frame end, or at sync in sync mode
   logic [31:0]  rx_buf_reg [`SLOTS];
   logic [`SLOTS-1:0] rx_got_reg;
   logic [`SLOTS-1:0] rx_got_next;
   rx_state_type rx_state_reg;
   rx_state_type rx_state_next;
   logic         apply_reg;
   logic         apply_next;
   logic [`SLOT_W:0] ap_idx_reg;
   logic [`SLOT_W:0] ap_idx_next;
   logic         sync_d_reg;
   wire logic    sync_rise = sync0_i && !sync_d_reg;
   logic [31:0] mod_reg [`MOD_REGS];
   logic [31:0] wnum;
   reg_access_type motor_wr_next;

   always_ff @(posedge clk_i)
   begin
      if (rx_word_i.valid)
         rx_buf_reg[rx_word_i.slot] <= rx_word_i.data;
   end

   always_comb
   begin
      rx_state_next = rx_state_reg;
      rx_got_next   = rx_got_reg;
      apply_next    = apply_reg;
      ap_idx_next   = ap_idx_reg;
      motor_wr_next = '0;
      wnum          = act_rx_reg[ap_idx_reg[`SLOT_W-1:0]];
      case (rx_state_reg)
         ST_IDLE:
            if (rx_frame_end_i)
            begin
               if (sync_mode_i)
                  rx_state_next = ST_HOLD; // (R1)
               else
               begin
                  apply_next  = 1'b1;
                  ap_idx_next = '0;
               end
            end
         ST_HOLD:
            if (sync_rise)
            begin
               rx_state_next = ST_IDLE; // (R1) (R19)
               apply_next    = 1'b1;
               ap_idx_next   = '0;
            end
         default: rx_state_next = ST_IDLE;
      endcase
      if (apply_reg)
      begin
         if (ap_idx_reg >= slot_lim || wnum == 32'h0) // (R10)
         begin
            apply_next  = 1'b0;
            rx_got_next = '0;
         end
         else
         begin
            ap_idx_next = ap_idx_reg + 4'h1;
            if (rx_got_reg[ap_idx_reg[`SLOT_W-1:0]] && wnum[31:16] == 16'h0)
            begin
               motor_wr_next.valid  = 1'b1; // (R6)
               motor_wr_next.number = wnum;
               motor_wr_next.data   = rx_buf_reg[ap_idx_reg[`SLOT_W-1:0]];
            end
         end
      end
      // A word arriving as the apply ends must not be lost, so the set wins
      if (rx_word_i.valid)
         rx_got_next[rx_word_i.slot] = 1'b1;
   end

   wire logic [3:0] msub = wnum[19:16];
   wire logic mod_wr = apply_reg && ap_idx_reg < slot_lim && wnum != 32'h0
                       && wnum[31:16] != 16'h0 && rx_got_reg[ap_idx_reg[`SLOT_W-1:0]];
   wire logic [31:0] mod_wdata = rx_buf_reg[ap_idx_reg[`SLOT_W-1:0]];

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_state_reg <= ST_IDLE;
         rx_got_reg   <= '0;
         apply_reg    <= 1'b0;
         ap_idx_reg   <= '0;
         motor_wr_o   <= '0;
         sync_d_reg   <= 1'b0;
      end
      else
      begin
         rx_state_reg <= rx_state_next;
         rx_got_reg   <= rx_got_next;
         apply_reg    <= apply_next;
         ap_idx_reg   <= ap_idx_next;
         motor_wr_o   <= motor_wr_next;
         sync_d_reg   <= sync0_i;
      end
   end

   // ==========================================================
   // Module registers; subindex = number / 65536 (R8)
   logic sync_diag_reg;
   logic sync_diag_next;
   always_comb
   begin
      sync_diag_next = sync_diag_reg;
      if (mod_wr && msub == `CMD_SUB)
      begin
         if (mod_wdata[7:0] == `CMD_SYNC_ON)
            sync_diag_next = 1'b1; // (R3)
         else if (mod_wdata[7:0] == `CMD_SYNC_OFF)
            sync_diag_next = 1'b0; // (R4)
      end
      if (wr_i && addr_i == `CMD_SUB)
      begin
         if (wdata_i[7:0] == `CMD_SYNC_ON)
            sync_diag_next = 1'b1; // (R3)
         else if (wdata_i[7:0] == `CMD_SYNC_OFF)
            sync_diag_next = 1'b0; // (R4)
      end
   end
   generate
      for (g = 0; g < `MOD_REGS; g++)
      begin : mod_g
         always_ff @(posedge clk_i or negedge rst_n)
         begin
            if (!rst_n)
               mod_reg[g] <= 32'h0;
            else if (wr_i && addr_i == 4'(g))
               mod_reg[g] <= wdata_i;
            else if (mod_wr && msub == 4'(g))
               mod_reg[g] <= mod_wdata; // (R8)
         end
      end
   endgenerate

   // ==========================================================
   // Diagnostic pulse
   logic [`PULSE_CW-1:0] pcnt_reg;
   logic [`PULSE_CW-1:0] pcnt_next;
   always_comb
   begin
      pcnt_next = pcnt_reg;
      if (!sync_diag_reg)
         pcnt_next = '0; // (R20)
      else if (sync_rise)
         pcnt_next = `PULSE_CW'(`PULSE_CYC); // (R3)
      else if (pcnt_reg != '0)
         pcnt_next = pcnt_reg - `PULSE_CW'(1);
   end
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_diag_reg        <= 1'b0;
         pcnt_reg             <= '0;
         general_output_one_o <= 1'b0;
      end
      else
      begin
         sync_diag_reg        <= sync_diag_next;
         pcnt_reg             <= pcnt_next;
         general_output_one_o <= sync_diag_next && pcnt_next != '0; // (R20)
      end
   end

   // ==========================================================
   // Transmit path: one slot per two cycles (address, then data)
   logic             tx_run_reg;
   logic             tx_run_next;
   logic             tx_ph_reg;
   logic             tx_ph_next;
   logic [`SLOT_W:0] tx_idx_reg;
   logic [`SLOT_W:0] tx_idx_next;
   slot_word_type    tx_word_next;
   logic [15:0]      raddr_next;
   logic [31:0]      tnum;
   always_comb
   begin
      tx_run_next  = tx_run_reg;
      tx_ph_next   = tx_ph_reg;
      tx_idx_next  = tx_idx_reg;
      tx_word_next = '0;
      raddr_next   = motor_raddr_o;
      tnum         = act_tx_reg[tx_idx_reg[`SLOT_W-1:0]];
      if (!tx_run_reg)
      begin
         if (tx_start_i)
         begin
            tx_run_next = 1'b1;
            tx_ph_next  = 1'b0;
            tx_idx_next = '0;
         end
      end
      else if (tx_idx_reg >= slot_lim || tnum == 32'h0) // (R10)
         tx_run_next = 1'b0;
      else if (!tx_ph_reg)
      begin
         raddr_next = tnum[15:0];
         tx_ph_next = 1'b1;
      end
      else
      begin
         tx_word_next.valid = 1'b1; // (R6)
         tx_word_next.slot  = tx_idx_reg[`SLOT_W-1:0];
         tx_word_next.data  = (tnum[31:16] != 16'h0) ? mod_reg[tnum[19:16]] : motor_rdata_i;
         tx_ph_next         = 1'b0;
         tx_idx_next        = tx_idx_reg + 4'h1;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_run_reg    <= 1'b0;
         tx_ph_reg     <= 1'b0;
         tx_idx_reg    <= '0;
         tx_word_o     <= '0;
         motor_raddr_o <= 16'h0;
         rdata_o       <= 32'h0;
      end
      else
      begin
         tx_run_reg    <= tx_run_next;
         tx_ph_reg     <= tx_ph_next;
         tx_idx_reg    <= tx_idx_next;
         tx_word_o     <= tx_word_next;
         motor_raddr_o <= raddr_next;
         rdata_o       <= rd_i ? ((addr_i == `CMD_SUB) ? {31'h0, sync_diag_reg}
                                                      : mod_reg[addr_i]) : 32'h0;
      end
   end

   // ==========================================================
   // Checks
   sequence cmd_on_s;
      mod_wr && msub == `CMD_SUB && mod_wdata[7:0] == `CMD_SYNC_ON && !wr_i;
   endsequence
   hold_until_sync_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (rx_state_reg == ST_HOLD && !sync_rise) |=> !apply_reg || $past(apply_reg)) // (R1)
      else $error("Data applied before sync");
   sync_on_cmd_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      cmd_on_s |=> sync_diag_reg) // (R3)
      else $error("Sync pulse not enabled");
   sync_off_cmd_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (wr_i && addr_i == `CMD_SUB && wdata_i[7:0] == `CMD_SYNC_OFF) |=> ##1 !general_output_one_o) // (R4)
      else $error("Pulse persists after disable");
   pulse_start_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (sync_diag_reg && sync_rise && !(wr_i && addr_i == `CMD_SUB)) |=> general_output_one_o) // (R3)
      else $error("No pulse on sync");
   pulse_off_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      !sync_diag_reg |=> !general_output_one_o) // (R20)
      else $error("Pulse while disabled");
   tx_limit_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      tx_word_o.valid |-> ({1'b0, tx_word_o.slot} < slot_lim)) // (R5)
      else $error("Slot beyond limit");
   zero_end_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (tx_run_reg && tnum == 32'h0) |=> !tx_run_reg ##1 !tx_word_o.valid) // (R10)
      else $error("Transfer past zero slot");
   motor_num_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      motor_wr_o.valid |-> motor_wr_o.number[31:16] == 16'h0 && motor_wr_o.number != 32'h0) // (R6)
      else $error("Bad motor write number");
   default_map_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (loaded_reg && !saved_user_reg && !stepper_i) |-> act_tx_reg[3] == {16'h0, `R_TRQ_ACT}) // (R11)
      else $error("Servo default map wrong");
endmodule

// >>> logic/pdo_mapper_cfg.svh
// Constants for the cyclic process-data mapper
// Behaviour
// (R1) In sync mode, received data is held and applied only at the next sync event.
// (R2) Master sends data early enough that it arrives before the sync event.
// (R3) Command 0x13 enables one output pulse per sync event.
// (R4) Command 0x14 disables the sync diagnostic pulse.
// (R5) One receive and one transmit object, five or eight 32-bit slots.
// (R6) Transmit carries register values out; receive writes values into mapped registers.
// (R7) Mapping is set by slots 16-31 and applies only after save and power cycle; the code takes the mapping writes on map_sub_i 0-15 instead.
// (R8) Module register number is 65536 times its subindex; command is subindex 15.
// (R9) Module register entries must follow all motor register entries.
// (R10) A zero slot ends the list; later slots are ignored.
// (R11) Servo default transmit map: 2, 10, 12, 169, 35.
// (R12) Servo default receive map: 2, 3, 5, 7.
// (R13) Stepper default transmit map: 2, 10, 12, 35, 36.
// (R14) Stepper default receive map: 2, 3, 5, 6.
// (R15) Servo master must not cyclically write registers 35, 36, 211.
// (R16) Stepper master must not cyclically write registers 24, 35, 36.
// (R17) Master sign-extends 16-bit quantities on the low-power servo.
// (R18) Sync mode change needs master reconfiguration and restart.
// (R19) Sync periods of 1 ms and 2 ms; update aligned to sync event.
// (R20) Diagnostic pulse is one fixed-width high pulse, low at reset and when disabled.
`ifndef PDO_MAPPER_CFG_SVH
`define PDO_MAPPER_CFG_SVH
// ==========================================================
// Sizes
`define SLOTS          8
`define SLOTS_SHORT    5
`define SLOT_W         3
`define MOD_REGS       16
`define MAP_BASE_SUB   16
// ==========================================================
// Encodings
`define MOD_UNIT       32'h0001_0000
`define CMD_SUB        4'hF
`define CMD_SYNC_ON    8'h13
`define CMD_SYNC_OFF   8'h14
`define R_MODE         16'h0002
`define R_POS_TGT      16'h0003
`define R_VEL_LIM      16'h0005
`define R_ACC_REQ      16'h0006
`define R_TRQ_LIM      16'h0007
`define R_POS_ACT      16'h000A
`define R_VEL_ACT      16'h000C
`define R_STATUS       16'h0023
`define R_WARN         16'h0024
`define R_TRQ_ACT      16'h00A9
// ==========================================================
// Timing at 50 MHz
`define CLK_MHZ        50
`define PULSE_US       10
`define PULSE_CYC      (`PULSE_US * `CLK_MHZ)
`define PULSE_CW       10
`endif

// >>> logic/pdo_mapper_pkg.sv
// Types for the cyclic process-data mapper
package pdo_mapper_pkg;
   typedef struct packed
   {
      logic        valid;
      logic [2:0]  slot;
      logic [31:0] data;
   } slot_word_type;
   typedef struct packed
   {
      logic        valid;
      logic [31:0] number;
      logic [31:0] data;
   } reg_access_type;
   typedef enum logic [1:0] {ST_IDLE, ST_HOLD} rx_state_type;
endpackage

// >>> verif/pdo_master_model.sv
// Fieldbus master model that feeds receive objects and requests transmit objects
`timescale 1ns/1ns
module pdo_master_model
(
   // Clock
   input  wire logic                     clk_i,
   // Towards the mapper
   output pdo_mapper_pkg::slot_word_type rx_word_o,
   output logic                          rx_frame_end_o,
   output logic                          tx_start_o
);
   import pdo_mapper_pkg::*;

   logic [31:0] last_data;

   initial
   begin
      rx_word_o      = '0;
      rx_frame_end_o = 1'b0;
      tx_start_o     = 1'b0;
      last_data      = 32'h0;
   end

   // ==========================================================
   // Receive object
   // Values already travel as full 32-bit words, sign extended by the sender
   // Callers start a frame well before the sync event they aim at
   task automatic send_frame(input logic [7:0] mask, input logic [7:0][31:0] words);
      for (int i = 0; i < 8; i++)
      begin
         if (mask[i])
         begin
            @(posedge clk_i);
            rx_word_o <= '{valid: 1'b1, slot: 3'(i), data: words[i]};
            last_data = words[i];
         end
      end
      @(posedge clk_i);
      // Released data line shows the inverse, so stale data is never mistaken for fresh
      rx_word_o      <= '{valid: 1'b0, slot: 3'h0, data: ~last_data};
      rx_frame_end_o <= 1'b1;
      @(posedge clk_i);
      rx_frame_end_o <= 1'b0;
   endtask

   // ==========================================================
   // Transmit request
   task automatic request_tx();
      @(posedge clk_i);
      tx_start_o <= 1'b1;
      @(posedge clk_i);
      tx_start_o <= 1'b0;
   endtask
endmodule

// >>> verif/pdo_mapper_bench.sv
// Self-checking bench for the cyclic process-data mapper
`timescale 1ns/1ns
module pdo_mapper_bench;
   import pdo_mapper_pkg::*;

   logic          clk_i = 1'b0;
   logic          resetn_i, stepper_i, eight_slots_i, sync_mode_i, sync0_i;
   logic          map_wr_i, save_i, wr_i, rd_i, rx_frame_end_i, tx_start_i;
   logic [4:0]    map_sub_i;
   logic [31:0]   map_data_i, wdata_i, rdata_o, motor_rdata_i, rd_val;
   logic [3:0]    addr_i;
   logic [15:0]   motor_raddr_o;
   logic          general_output_one_o;
   slot_word_type rx_word_i, tx_word_o;
   reg_access_type motor_wr_o;
   logic [34:0]   tx_q[$];
   logic [63:0]   wr_q[$];
   int            n_fail = 0, compares = 0, cycles = 0, diag_cnt = 0;

   always #10 clk_i = ~clk_i;
   // Motor answers with a tag plus the address it was asked for
   assign motor_rdata_i = {16'hC0DE, motor_raddr_o};

   pdo_mapper i_pdo_mapper (.clk_i(clk_i), .resetn_i(resetn_i), .stepper_i(stepper_i),
      .eight_slots_i(eight_slots_i), .sync_mode_i(sync_mode_i), .sync0_i(sync0_i),
      .map_wr_i(map_wr_i), .map_sub_i(map_sub_i), .map_data_i(map_data_i), .save_i(save_i),
      .rx_word_i(rx_word_i), .rx_frame_end_i(rx_frame_end_i), .tx_start_i(tx_start_i),
      .motor_rdata_i(motor_rdata_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .motor_wr_o(motor_wr_o), .motor_raddr_o(motor_raddr_o),
      .tx_word_o(tx_word_o), .general_output_one_o(general_output_one_o));

   pdo_master_model i_pdo_master_model (.clk_i(clk_i), .rx_word_o(rx_word_i),
      .rx_frame_end_o(rx_frame_end_i), .tx_start_o(tx_start_i));

   // ==========================================================
   // Monitors and hang limit
   always @(posedge clk_i)
   begin
      cycles++;
      if (tx_word_o.valid === 1'b1)
         tx_q.push_back({tx_word_o.slot, tx_word_o.data});
      if (motor_wr_o.valid === 1'b1)
         wr_q.push_back({motor_wr_o.number, motor_wr_o.data});
      if (general_output_one_o === 1'b1)
         diag_cnt++;
      if (cycles == 20000)
      begin
         n_fail++;
         final_report();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      if (n_fail == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Mode changes only across a restart, as the master must reconfigure
   task automatic do_reset(input logic stp, input logic smode);
      @(posedge clk_i);
      resetn_i    <= 1'b0;
      stepper_i   <= stp;
      sync_mode_i <= smode;
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      tx_q.delete();
      wr_q.delete();
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      d = rdata_o;
   endtask

   task automatic map_wr(input logic [4:0] s, input logic [31:0] n);
      @(posedge clk_i);
      map_wr_i   <= 1'b1;
      map_sub_i  <= s;
      map_data_i <= n;
      @(posedge clk_i);
      map_wr_i <= 1'b0;
   endtask

   task automatic pulse_sync();
      @(negedge clk_i);
      diag_cnt = 0;
      @(posedge clk_i);
      sync0_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      sync0_i <= 1'b0;
   endtask

   task automatic run_tx(input logic [7:0][15:0] regs, input int n);
      tx_q.delete();
      i_pdo_master_model.request_tx();
      repeat (30) @(posedge clk_i);
      chk_val(32'(tx_q.size()), 32'(n));
      for (int i = 0; i < n && i < tx_q.size(); i++)
      begin
         chk_val(32'(tx_q[i][34:32]), 32'(i));
         chk_val(tx_q[i][31:0], {16'hC0DE, regs[i]});
      end
   endtask

   task automatic chk_wr(input logic [7:0][15:0] regs, input logic [7:0][31:0] w, input int n);
      chk_val(32'(wr_q.size()), 32'(n));
      for (int i = 0; i < n && i < wr_q.size(); i++)
      begin
         chk_val(wr_q[i][63:32], {16'h0, regs[i]});
         chk_val(wr_q[i][31:0], w[i]);
      end
      wr_q.delete();
   endtask

   // ==========================================================
   // Scenarios
   logic [7:0][31:0] words = {32'h8888, 32'h7777, 32'h6666, 32'h5555,
                              32'h4444, 32'h3333, 32'h0013, 32'h1111};

   task automatic servo_defaults();
      chk_val(32'(general_output_one_o), 32'h0);
      run_tx({16'h0, 16'h0, 16'h0, 16'h23, 16'hA9, 16'hC, 16'hA, 16'h2}, 5);
      // Receive map never carries 35, 36 or 211
      i_pdo_master_model.send_frame(8'h0F, words);
      repeat (30) @(posedge clk_i);
      chk_wr({16'h0, 16'h0, 16'h0, 16'h0, 16'h7, 16'h5, 16'h3, 16'h2}, words, 4);
   endtask

   task automatic diag_pulse();
      wr_reg(4'h3, 32'hA5A5_0001);
      rd_reg(4'h3, rd_val);
      chk_val(rd_val, 32'hA5A5_0001);
      wr_reg(4'hF, 32'h13);
      rd_reg(4'hF, rd_val);
      chk_val(rd_val, 32'h1);
      chk_val(32'(general_output_one_o), 32'h0);
      pulse_sync();
      repeat (700) @(posedge clk_i);
      chk_val(32'(diag_cnt), 32'h1F4);
      wr_reg(4'hF, 32'h14);
      rd_reg(4'hF, rd_val);
      chk_val(rd_val, 32'h0);
      pulse_sync();
      repeat (700) @(posedge clk_i);
      chk_val(32'(diag_cnt), 32'h0);
   endtask

   task automatic stepper_sync();
      do_reset(1'b1, 1'b1);
      eight_slots_i <= 1'b1;
      run_tx({16'h0, 16'h0, 16'h0, 16'h24, 16'h23, 16'hC, 16'hA, 16'h2}, 5);
      // Receive map never carries 24, 35 or 36
      i_pdo_master_model.send_frame(8'h0F, words);
      repeat (40) @(posedge clk_i);
      chk_val(32'(wr_q.size()), 32'h0);
      pulse_sync();
      repeat (30) @(posedge clk_i);
      chk_wr({16'h0, 16'h0, 16'h0, 16'h0, 16'h6, 16'h5, 16'h3, 16'h2}, words, 4);
   endtask

   task automatic user_map();
      for (int i = 0; i < 7; i++)
         map_wr(5'(8 + i), 32'(i + 2));
      map_wr(5'h0F, 32'h0);
      map_wr(5'h00, 32'h3);
      // Module entry placed after the motor entry
      map_wr(5'h01, 32'h000F_0000);
      map_wr(5'h02, 32'h0);
      map_wr(5'h03, 32'h5);
      @(posedge clk_i);
      save_i <= 1'b1;
      @(posedge clk_i);
      save_i <= 1'b0;
      run_tx({16'h0, 16'h0, 16'h0, 16'h24, 16'h23, 16'hC, 16'hA, 16'h2}, 5);
      do_reset(1'b0, 1'b0);
      eight_slots_i <= 1'b0;
      run_tx({16'h0, 16'h8, 16'h7, 16'h6, 16'h5, 16'h4, 16'h3, 16'h2}, 5);
      eight_slots_i <= 1'b1;
      run_tx({16'h0, 16'h8, 16'h7, 16'h6, 16'h5, 16'h4, 16'h3, 16'h2}, 7);
      i_pdo_master_model.send_frame(8'h0B, words);
      repeat (30) @(posedge clk_i);
      chk_wr({16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h3}, words, 1);
      rd_reg(4'hF, rd_val);
      chk_val(rd_val, 32'h1);
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      resetn_i      = 1'b0;
      stepper_i     = 1'b0;
      eight_slots_i = 1'b0;
      sync_mode_i   = 1'b0;
      sync0_i       = 1'b0;
      map_wr_i      = 1'b0;
      map_sub_i     = 5'h0;
      map_data_i    = 32'h0;
      save_i        = 1'b0;
      addr_i        = 4'h0;
      wdata_i       = 32'h0;
      wr_i          = 1'b0;
      rd_i          = 1'b0;
      do_reset(1'b0, 1'b0);
      servo_defaults();
      diag_pulse();
      stepper_sync();
      user_map();
      final_report();
   end
endmodule
